// ==== core/i2c_ctrl.sv ====
// Two-wire bus controller, master and slave, bit and byte engines
`include "i2c_ctrl_consts.svh"
module i2c_ctrl
    import i2c_ctrl_pkg::*;
#(
    parameter int PHASE = `PHASE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Control
    input wire logic [31:0] i_control_register,
    input wire logic [6:0] i_own_slave_address_register,
    input wire logic [15:0] i_timeout_limit,
    // Master requests
    input wire logic i_go,
    input wire logic [7:0] i_tx_data,
    input wire logic i_send_start,
    input wire logic i_send_stop,
    input wire logic i_read,
    input wire logic i_is_address,
    input wire logic i_ack_to_send,
    // Results
    output logic o_done,
    output logic [7:0] o_rx_data,
    output logic o_ack_seen,
    output logic o_busy,
    output logic o_slave_mode,
    output event_type o_events,
    output logic o_irq,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_oe,
    output logic o_sda_oe,
    output logic o_scl_out,
    output logic o_sda_out
);
    // ----------------------------------------------------------------
    // Pin synchronisers and condition detection
    // ----------------------------------------------------------------
    logic [1:0] scl_sync, sda_sync;
    logic scl_q, sda_q;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end
    wire logic scl_s = scl_sync[1];
    wire logic sda_s = sda_sync[1];
    wire logic start_seen = scl_s && scl_q && sda_q && !sda_s;
    wire logic stop_seen = scl_s && scl_q && !sda_q && sda_s;
    wire logic scl_rise = scl_s && !scl_q;
    wire logic scl_fall = !scl_s && scl_q;
    wire logic bus_idle = scl_s && sda_s;

    // Busy holds across repeated start, drops some time after stop
    logic bus_busy;
    logic [15:0] idle_cnt;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus_busy <= 1'b0;
            idle_cnt <= 16'h0;
        end else if (start_seen) begin
            bus_busy <= 1'b1;
            idle_cnt <= 16'h0;
        end else if (bus_busy && bus_idle && idle_cnt != 16'hffff) begin
            idle_cnt <= idle_cnt + 16'h1;
            if (idle_cnt >= `BUSY_HOLD_CYCLES)
                bus_busy <= 1'b0;
        end else if (!bus_idle) begin
            idle_cnt <= 16'h0;
        end
    end

    // ----------------------------------------------------------------
    // Control fields and phase timer
    // ----------------------------------------------------------------
    wire logic core_enable_bit = i_control_register[`CTL_CORE_EN];
    wire logic irq_enable_bit = i_control_register[`CTL_IRQ_EN];
    wire logic mode_bit = i_control_register[`CTL_MODE];
    wire logic ten_bit_addr_select = i_control_register[`CTL_TEN_BIT_ADDR_SELECT];
    wire logic dir_override_value = i_control_register[`CTL_OVR_VAL];
    wire logic dir_override_enable = i_control_register[`CTL_OVR_EN];
    // Master only once mode set with core enable dropped; ten-bit unsupported
    wire logic master_sel = mode_bit && !core_enable_bit && !ten_bit_addr_select;

    logic [15:0] ph_cnt;
    wire logic ph_tick = (ph_cnt == 16'(PHASE - 1));
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || ph_tick)
            ph_cnt <= 16'h0;
        else
            ph_cnt <= ph_cnt + 16'h1;
    end

    // ----------------------------------------------------------------
    // Bit-level engine
    // ----------------------------------------------------------------
    bit_state_type bst;
    bit_cmd_type bcmd;
    logic bit_out, bit_in, scl_drv_low, sda_drv_low;
    wire logic bit_done = (bst == BIT_DONE);
    // Clock stretching: phase C waits until the clock line is actually high
    wire logic stretch = (bst == BIT_C) && !scl_s;
    wire logic last_phase = (bst == BIT_D) || (bst == BIT_C && bcmd == CMD_STOP);
    bit_cmd_type issue_cmd;
    logic issue_bit;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bst <= BIT_IDLE;
            bcmd <= CMD_NONE;
            bit_out <= 1'b1;
            bit_in <= 1'b0;
            scl_drv_low <= 1'b0;
            sda_drv_low <= 1'b0;
        end else begin
            case (bst)
                BIT_IDLE: if (issue_cmd != CMD_NONE && ph_tick) begin
                    bcmd <= issue_cmd;
                    bit_out <= issue_bit;
                    bst <= BIT_A;
                    case (issue_cmd)
                        CMD_START: begin sda_drv_low <= 1'b0; end
                        CMD_STOP: begin sda_drv_low <= 1'b1; end
                        CMD_WRITE: begin sda_drv_low <= !issue_bit; end
                        default: begin sda_drv_low <= 1'b0; end
                    endcase
                end
                BIT_A: if (ph_tick) begin
                    bst <= BIT_B;
                    scl_drv_low <= 1'b0;
                end
                BIT_B: if (ph_tick) begin
                    bst <= BIT_C;
                    if (bcmd == CMD_START)
                        sda_drv_low <= 1'b1;
                    if (bcmd == CMD_STOP)
                        sda_drv_low <= 1'b0;
                end
                BIT_C: if (ph_tick && !stretch) begin
                    bit_in <= sda_s;
                    bst <= last_phase ? BIT_DONE : BIT_D;
                end
                BIT_D: if (ph_tick) begin
                    if (bcmd != CMD_STOP)
                        scl_drv_low <= 1'b1;
                    bst <= BIT_DONE;
                end
                BIT_DONE: bst <= BIT_IDLE;
                default: bst <= BIT_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Byte-level engine (master) and slave receiver
    // ----------------------------------------------------------------
    byte_state_type by;
    logic [7:0] shreg;
    logic [3:0] bit_cnt;
    logic do_read, ack_bit;
    logic [15:0] low_cnt;
    addr_byte_type abyte;
    always_comb begin
        abyte = addr_byte_type'(i_tx_data);
        if (i_is_address && dir_override_enable)
            abyte.rw = dir_override_value;
        // Otherwise the lsb of the programmed address is the direction
    end
    wire logic byte_active = (by == BY_START || by == BY_SHIFT || by == BY_ACK || by == BY_STOP);
    always_comb begin
        issue_cmd = CMD_NONE;
        issue_bit = 1'b1;
        case (by)
            BY_START: issue_cmd = CMD_START;
            BY_SHIFT: begin
                issue_cmd = do_read ? CMD_READ : CMD_WRITE;
                issue_bit = shreg[7];
            end
            BY_ACK: begin
                issue_cmd = do_read ? CMD_WRITE : CMD_READ;
                issue_bit = i_ack_to_send;
            end
            BY_STOP: issue_cmd = CMD_STOP;
            default: issue_cmd = CMD_NONE;
        endcase
    end

    logic [2:0] sl_cnt;
    logic [7:0] sl_shift;
    logic sl_addr_phase, sl_hit, sl_ack_drive, sl_ack_pend, sl_ack_want, sl_in_ack;
    wire logic addr_match = (sl_shift[6:0] == i_own_slave_address_register);
    event_type ev;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            by <= BY_IDLE;
            shreg <= 8'h0;
            bit_cnt <= 4'h0;
            do_read <= 1'b0;
            ack_bit <= 1'b1;
            o_done <= 1'b0;
            o_rx_data <= 8'h0;
            o_ack_seen <= 1'b0;
            low_cnt <= 16'h0;
            sl_cnt <= 3'h0;
            sl_shift <= 8'h0;
            sl_addr_phase <= 1'b0;
            sl_hit <= 1'b0;
            sl_ack_drive <= 1'b0;
            sl_ack_pend <= 1'b0;
            sl_ack_want <= 1'b0;
            sl_in_ack <= 1'b0;
            ev <= '0;
        end else begin
            o_done <= 1'b0;
            ev <= '0;
            ev.start_det <= start_seen;
            ev.stop_det <= stop_seen;
            low_cnt <= (scl_s || by == BY_IDLE) ? 16'h0 : low_cnt + 16'h1;
            case (by)
                BY_IDLE: if (i_go && master_sel) begin
                    shreg <= abyte;
                    do_read <= i_read;
                    bit_cnt <= 4'h0;
                    by <= i_send_start ? BY_START : BY_SHIFT;
                end
                BY_START: if (bit_done) by <= BY_SHIFT;
                BY_SHIFT: if (bit_done) begin
                    shreg <= {shreg[6:0], bit_in};
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == `BITS_PER_BYTE - 4'h1)
                        by <= BY_ACK;
                end
                BY_ACK: if (bit_done) begin
                    ack_bit <= bit_in;
                    by <= i_send_stop ? BY_STOP : BY_WAIT;
                end
                BY_STOP: if (bit_done) by <= BY_WAIT;
                BY_WAIT: begin
                    o_done <= 1'b1;
                    o_rx_data <= shreg;
                    o_ack_seen <= !ack_bit;
                    ev.master_done <= 1'b1;
                    by <= BY_IDLE;
                end
                default: by <= BY_IDLE;
            endcase
            if (byte_active && low_cnt >= i_timeout_limit && i_timeout_limit != 16'h0) begin
                ev.timeout <= 1'b1;
                by <= BY_IDLE;
            end
            // Slave receiver: samples on clock rise, never drives start/stop
            if (start_seen) begin
                sl_cnt <= 3'h0;
                sl_addr_phase <= 1'b1;
                sl_hit <= 1'b0;
                sl_ack_drive <= 1'b0;
                sl_ack_pend <= 1'b0;
                sl_in_ack <= 1'b0;
            end else if (!master_sel && scl_rise && !sl_in_ack) begin
                sl_shift <= {sl_shift[6:0], sda_s};
                sl_cnt <= sl_cnt + 3'h1;
                if (sl_cnt == 3'h7) begin
                    if (sl_addr_phase)
                        sl_hit <= addr_match;
                    else if (sl_hit) begin
                        o_rx_data <= {sl_shift[6:0], sda_s};
                        ev.slave_rx <= 1'b1;
                    end
                    sl_ack_pend <= 1'b1;
                    sl_ack_want <= sl_addr_phase ? addr_match : sl_hit;
                    sl_addr_phase <= 1'b0;
                end
            end else if (scl_fall && sl_ack_pend) begin
                // Ack only once the clock is low, else it would look like a start
                sl_ack_pend <= 1'b0;
                sl_in_ack <= 1'b1;
                sl_ack_drive <= sl_ack_want;
            end else if (scl_fall && sl_in_ack) begin
                // Release after the ack clock falls, never while it is high
                sl_in_ack <= 1'b0;
                sl_ack_drive <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_busy <= 1'b0;
            o_slave_mode <= 1'b1;
            o_events <= '0;
            o_irq <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
        end else begin
            o_busy <= bus_busy;
            o_slave_mode <= !master_sel;
            o_events <= ev;
            o_irq <= irq_enable_bit && (ev != '0);
            o_scl_oe <= master_sel && scl_drv_low;
            o_sda_oe <= master_sel ? sda_drv_low : sl_ack_drive;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
        end
    end
endmodule : i2c_ctrl

// ==== core/i2c_ctrl_consts.svh ====
// Constants for the two-wire bus controller
// Notes on behaviour
// - Data line changes only while clock low; stable while clock high.
// - Master makes exactly one clock pulse per data bit.
// - Bit operations use idle,A,B,C,D phases; stop uses idle,A,B,C.
// - A byte read is eight single-bit read commands.
// - Start: data falls while clock high; detector flags it.
// - Stop: data rises while clock high; detector flags it.
// - Only master generates start and stop; slave never does.
// - Busy holds through repeated start, clears after stop.
// - First byte: seven address bits then direction, 0 write 1 read.
// - Slave receiver acknowledges only its own address and the bytes after it.
// - Master clocks the ninth acknowledge bit; no new operation during it.
// - Override enable replaces address bit 0 with override value.
// - Override clear: address lsb gives direction.
// - Slave after reset; master when mode set with core enable and ten-bit cleared.
// - Three modes: master tx/rx, slave rx.
// - Slave rx mode matches the programmed own address.
// - Events: start, stop, timeout, master done, slave received.
// - Repeated start continues transfer without an intervening stop.
// - Control word holds enable, irq enable, mode, ten-bit, override fields.
// - Bus idle when both lines high.
// - Units are nine bits: eight data msb first, then acknowledge.
`ifndef I2C_CTRL_CONSTS_SVH
`define I2C_CTRL_CONSTS_SVH
`define CLK_HZ 25000000
`define BUS_HZ 100000
`define PHASE_CYCLES (`CLK_HZ / (`BUS_HZ * 4))
`define CTL_CORE_EN 0
`define CTL_IRQ_EN 1
`define CTL_MODE 2
`define CTL_TEN_BIT_ADDR_SELECT 3
`define CTL_OVR_VAL 4
`define CTL_OVR_EN 5
`define BITS_PER_BYTE 4'h8
`define BUSY_HOLD_CYCLES 16'h0080
`endif

// ==== core/i2c_ctrl_pkg.sv ====
// Types for the two-wire bus controller
package i2c_ctrl_pkg;
    typedef enum logic [5:0] {
        BIT_IDLE = 6'h01,
        BIT_A = 6'h02,
        BIT_B = 6'h04,
        BIT_C = 6'h08,
        BIT_D = 6'h10,
        BIT_DONE = 6'h20
    } bit_state_type;
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_START = 3'h1,
        CMD_STOP = 3'h2,
        CMD_WRITE = 3'h3,
        CMD_READ = 3'h4
    } bit_cmd_type;
    typedef enum logic [7:0] {
        BY_IDLE = 8'h01,
        BY_START = 8'h02,
        BY_SHIFT = 8'h04,
        BY_ACK = 8'h08,
        BY_STOP = 8'h10,
        BY_WAIT = 8'h20,
        BY_SADDR = 8'h40,
        BY_SDATA = 8'h80
    } byte_state_type;
    typedef struct packed {
        logic start_det;
        logic stop_det;
        logic timeout;
        logic master_done;
        logic slave_rx;
    } event_type;
    typedef struct packed {
        logic [6:0] addr;
        logic rw;
    } addr_byte_type;
endpackage : i2c_ctrl_pkg

// ==== tb/i2c_ctrl_checker.sv ====
// Concurrent assertions bound to the two-wire bus controller
`include "i2c_ctrl_consts.svh"
module i2c_ctrl_checker
    import i2c_ctrl_pkg::*;
#(
    parameter int PHASE = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Inputs seen
    input wire logic [31:0] i_control_register,
    input wire logic i_scl,
    input wire logic i_sda,
    // Outputs watched
    input wire logic o_done,
    input wire logic o_busy,
    input wire logic o_slave_mode,
    input wire event_type o_events,
    input wire logic o_irq,
    input wire logic o_scl_oe,
    input wire logic o_sda_oe
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // ----------------------------------------
    // Bus conditions and results
    // ----------------------------------------
    wire logic irq_en = i_control_register[`CTL_IRQ_EN];
    wire logic mst = i_control_register[`CTL_MODE] && !i_control_register[`CTL_CORE_EN];
    wire logic sel = mst && !i_control_register[`CTL_TEN_BIT_ADDR_SELECT];
    sequence s_start;
        i_scl && $past(i_scl) && $past(i_sda) && !i_sda;
    endsequence
    sequence s_stop;
        i_scl && $past(i_scl) && !$past(i_sda) && i_sda;
    endsequence
    property p_start; s_start |-> ##[1:6] o_events.start_det; endproperty
    a_start: assert property (p_start) else $error("start missed");
    property p_stop; s_stop |-> ##[1:6] o_events.stop_det; endproperty
    a_stop: assert property (p_stop) else $error("stop missed");
    property p_busy_hold; o_events.stop_det |=> o_busy [*8]; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_idle; $fell(o_busy) |-> i_scl && i_sda; endproperty
    a_idle: assert property (p_idle) else $error("busy fell on active bus");
    property p_irq; (|o_events) && irq_en |-> ##[0:1] o_irq; endproperty
    a_irq: assert property (p_irq) else $error("event without irq");
    property p_irq_off; !irq_en && !$past(irq_en) |-> !o_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_rst_slave; $past(i_sys_rst) |-> o_slave_mode; endproperty
    a_rst_slave: assert property (p_rst_slave) else $error("not slave after reset");
    property p_master; sel [*4] |-> !o_slave_mode; endproperty
    a_master: assert property (p_master) else $error("master not selected");
    property p_slv_cond;
        o_slave_mode && $past(o_slave_mode) && i_scl && $past(i_scl) |-> $stable(o_sda_oe);
    endproperty
    a_slv_cond: assert property (p_slv_cond) else $error("slave made a condition");
    property p_slv_clk; o_slave_mode |-> !o_scl_oe; endproperty
    a_slv_clk: assert property (p_slv_clk) else $error("slave drove clock");
    property p_done; o_done |-> !o_slave_mode && $past(mst); endproperty
    a_done: assert property (p_done) else $error("done outside master");
endmodule : i2c_ctrl_checker
bind i2c_ctrl i2c_ctrl_checker #(.PHASE(PHASE)) u_i2c_ctrl_checker (.*);

// ==== tb/i2c_ctrl_tb.sv ====
// Self-checking bench for the two-wire bus controller
`include "i2c_ctrl_consts.svh"
module i2c_ctrl_tb
    import i2c_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] DEV = 7'h2a;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [31:0] i_control_register = 32'h0;
    logic [6:0] i_own_slave_address_register = 7'h11;
    logic [15:0] i_timeout_limit = 16'h0;
    logic [7:0] i_tx_data = 8'h0;
    logic i_go = 1'b0;
    logic i_send_start = 1'b0;
    logic i_send_stop = 1'b0;
    logic i_read = 1'b0;
    logic i_is_address = 1'b0;
    logic i_ack_to_send = 1'b0;
    logic hold = 1'b0;
    logic b_scl_oe = 1'b0;
    logic b_sda_oe = 1'b0;
    logic seen_srx = 1'b0;
    logic seen_to = 1'b0;
    logic [7:0] rd_byte = 8'h0;
    logic [31:0] seed = 32'h7a2d0d43;
    logic o_done, o_ack_seen, o_busy, o_slave_mode, o_irq, o_scl_oe, o_sda_oe;
    logic o_scl_out, o_sda_out, m_scl_oe, m_sda_oe;
    logic [7:0] o_rx_data, last_byte;
    event_type o_events;
    wire logic i_scl = !(o_scl_oe || m_scl_oe || b_scl_oe);
    wire logic i_sda = !(o_sda_oe || m_sda_oe || b_sda_oe);
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int rises = 0;
    int n_done = 0;
    int n_evt = 0;
    i2c_ctrl #(.PHASE(2)) u_i2c_ctrl (.*);
    i2c_slave_model #(.DEV(DEV)) u_i2c_slave_model (.i_clk(i_clk), .i_scl(i_scl),
        .i_sda(i_sda), .i_hold_scl(hold), .i_rd_byte(rd_byte), .o_scl_oe(m_scl_oe),
        .o_sda_oe(m_sda_oe), .o_last_byte(last_byte));
    always #20 i_clk = ~i_clk;
    always @(posedge i_scl) rises++;
    always @(negedge i_clk) begin
        cycles++;
        seen_to = seen_to | (o_events.timeout === 1'b1);
        seen_srx = seen_srx | (o_events.slave_rx === 1'b1);
        n_done += int'(o_done === 1'b1);
        n_evt += int'(o_events.master_done === 1'b1);
        if (cycles > 8000) begin
            mismatches++;
            finish_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] addr_exp(input logic [7:0] d, input logic [31:0] c);
        return c[`CTL_OVR_EN] ? {d[7:1], c[`CTL_OVR_VAL]} : d;
    endfunction : addr_exp
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic check_bit(input string nm, input logic e, input logic g);
        check(nm, {7'h0, e}, {7'h0, g});
    endtask : check_bit
    // Flags are start, stop, read, address, ack value
    task automatic xfer(input logic [4:0] f, input logic [7:0] d, input int lim, output logic ok);
        @(negedge i_clk);
        {i_send_start, i_send_stop, i_read, i_is_address, i_ack_to_send} = f;
        i_tx_data = d;
        i_go = 1'b1;
        rises = 0;
        @(negedge i_clk);
        i_go = 1'b0;
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(negedge i_clk);
            ok = (o_done === 1'b1);
        end
    endtask : xfer
    // Bench as remote master; clock low on entry and on exit
    task automatic bb_bit(input logic b, output logic s);
        b_sda_oe = !b;
        repeat (6) @(negedge i_clk);
        b_scl_oe = 1'b0;
        repeat (6) @(negedge i_clk);
        s = i_sda;
        b_scl_oe = 1'b1;
        repeat (2) @(negedge i_clk);
    endtask : bb_bit
    task automatic bb_byte(input logic [7:0] v, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bb_bit(v[i], s);
        bb_bit(1'b1, a);
    endtask : bb_byte
    // Start from an idle bus, or stop from a low clock
    task automatic bb_cond(input logic stop);
        b_sda_oe = 1'b1;
        repeat (6) @(negedge i_clk);
        b_scl_oe = !stop;
        repeat (6) @(negedge i_clk);
        b_sda_oe = !stop;
        repeat (2) @(negedge i_clk);
    endtask : bb_cond
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic ok;
        logic [7:0] d;
        logic [7:0] e;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        check_bit("slave_mode", 1'b1, o_slave_mode);
        xfer(5'b11011, {DEV, 1'b0}, 300, ok);
        check_bit("go_in_slave", 1'b0, ok);
        $display("test refusal done");
        bb_cond(1'b0);
        bb_byte({i_own_slave_address_register, 1'b0}, ok);
        check_bit("slave_addr_ack", 1'b0, ok);
        seed = lfsr(seed);
        d = seed[7:0];
        bb_byte(d, ok);
        check_bit("slave_data_ack", 1'b0, ok);
        check("slave_rx_data", d, o_rx_data);
        check_bit("slave_rx_event", 1'b1, seen_srx);
        bb_cond(1'b1);
        bb_cond(1'b0);
        bb_byte({i_own_slave_address_register ^ 7'h01, 1'b0}, ok);
        check_bit("slave_addr_nack", 1'b1, ok);
        bb_cond(1'b1);
        check("pin_out", 8'h00, {6'h0, o_scl_out, o_sda_out});
        $display("test slave receive done");
        i_control_register = 32'h00000006;
        i_own_slave_address_register = seed[6:0];
        repeat (4) @(negedge i_clk);
        check_bit("slave_mode", 1'b0, o_slave_mode);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            i_control_register[`CTL_OVR_EN] = i[1];
            i_control_register[`CTL_OVR_VAL] = i[0];
            d = {DEV, seed[0]};
            e = addr_exp(d, i_control_register);
            rd_byte = seed[15:8];
            xfer({1'b1, !e[0], 3'b011}, d, 3000, ok);
            check("addr_byte", e, last_byte);
            check_bit("addr_ack", 1'b1, o_ack_seen);
            if (e[0]) begin
                xfer(5'b01101, 8'h00, 3000, ok);
                check("read_byte", rd_byte, o_rx_data);
            end
        end
        $display("test override done");
        i_control_register[`CTL_OVR_EN] = 1'b0;
        xfer(5'b10011, {DEV, 1'b0}, 3000, ok);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            xfer({1'b0, i == 2, 3'b001}, d, 3000, ok);
            check("write_byte", d, last_byte);
            check_bit("write_ack", 1'b1, o_ack_seen);
            if (i < 2) check("scl_pulses", 8'h09, rises[7:0]);
        end
        check_bit("busy_after_stop", 1'b1, o_busy);
        repeat (200) @(negedge i_clk);
        check_bit("busy_idle", 1'b0, o_busy);
        $display("test write burst done");
        seed = lfsr(seed);
        xfer(5'b10011, {DEV, 1'b0}, 3000, ok);
        xfer(5'b00001, seed[7:0], 3000, ok);
        check_bit("busy_before_rs", 1'b1, o_busy);
        rd_byte = seed[15:8];
        xfer(5'b10011, {DEV, 1'b1}, 3000, ok);
        check("rs_addr", {DEV, 1'b1}, last_byte);
        xfer(5'b01101, 8'h00, 3000, ok);
        check("rs_read", rd_byte, o_rx_data);
        xfer(5'b11011, {~DEV, 1'b0}, 3000, ok);
        check_bit("nack", 1'b0, o_ack_seen);
        $display("test repeated start done");
        i_timeout_limit = 16'h0020;
        fork
            begin
                repeat (30) @(negedge i_clk);
                hold = 1'b1;
            end
            xfer(5'b10011, {DEV, 1'b0}, 400, ok);
        join
        check_bit("timeout_event", 1'b1, seen_to);
        check_bit("timeout_no_done", 1'b0, ok);
        check("done_events", n_done[7:0], n_evt[7:0]);
        hold = 1'b0;
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        check_bit("slave_after_reset", 1'b1, o_slave_mode);
        $display("test timeout done");
        finish_test();
    end
endmodule : i2c_ctrl_tb

// ==== tb/i2c_slave_model.sv ====
// Remote slave device answering the controller on the bus
module i2c_slave_model #(
    parameter logic [6:0] DEV = 7'h2a
) (
    // Clock and bus
    input wire logic i_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    // Bench controls
    input wire logic i_hold_scl,
    input wire logic [7:0] i_rd_byte,
    // Drive and capture
    output logic o_scl_oe,
    output logic o_sda_oe,
    output logic [7:0] o_last_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic first = 1'b0;
    logic hit = 1'b0;
    logic rd = 1'b0;
    logic mack = 1'b0;
    logic drv = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] sh = 8'h0;
    logic [7:0] tx = 8'h0;
    wire logic go_rd = hit && rd && (first || mack);
    initial o_sda_oe = 1'b0;
    initial o_last_byte = 8'h0;
    // Stretching only on request, to provoke a clock-low timeout
    assign o_scl_oe = i_hold_scl;
    always @(posedge i_clk) begin
        scl_q <= i_scl;
        sda_q <= i_sda;
        if (i_scl && scl_q && sda_q && !i_sda) begin
            cnt <= 4'h0;
            first <= 1'b1;
            drv <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (i_scl && scl_q && !sda_q && i_sda) begin
            hit <= 1'b0;
            o_sda_oe <= 1'b0;
        end else if (i_scl && !scl_q) begin
            sh <= (cnt < 4'h8) ? {sh[6:0], i_sda} : sh;
            mack <= (cnt == 4'h9) ? !i_sda : mack;
            cnt <= (cnt < 4'h8) ? cnt + 4'h1 : cnt;
        end else if (!i_scl && scl_q) begin
            if (cnt == 4'h8) begin
                o_last_byte <= sh;
                hit <= first ? (sh[7:1] == DEV) : hit;
                rd <= first ? sh[0] : rd;
                o_sda_oe <= first ? (sh[7:1] == DEV) : (hit && !rd);
                cnt <= 4'h9;
            end else if (cnt == 4'h9) begin
                cnt <= 4'h0;
                first <= 1'b0;
                drv <= go_rd;
                tx <= {i_rd_byte[6:0], 1'b1};
                o_sda_oe <= go_rd && !i_rd_byte[7];
            end else begin
                tx <= {tx[6:0], 1'b1};
                o_sda_oe <= drv && !tx[7];
            end
        end
    end
endmodule : i2c_slave_model
